// >>> orsq_sequencer.sv
// output turn-on/turn-off sequencer with timing words and fault summary
`include "orsq_map.svh"

module orsq_sequencer #(
    parameter logic [7:0] CLEAR_CODE = 8'h03,
    parameter int PHASE_MAX = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [3:0] i_phases,
    input wire logic [15:0] i_ton_delay,
    input wire logic [15:0] i_mp_ramp_gain,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic i_flt_busy,
    input wire logic i_flt_ov,
    input wire logic i_flt_oc,
    input wire logic i_flt_uvin,
    input wire logic i_flt_temp,
    input wire logic i_flt_cml,
    input wire logic i_flt_other,
    input wire logic [7:0] i_stat_hi,
    output logic o_cmd_ack,
    output logic o_cmd_nack,
    output logic [15:0] o_cmd_rdata,
    output logic o_ramp_up,
    output logic o_ramp_down,
    output logic o_stage_on,
    output logic o_pwm_tristate,
    output orsq_pkg::orsq_state_type o_state
);
    import orsq_pkg::*;

    generate
        if (PHASE_MAX != 8) begin : g_phase_check
            $error("orsq_sequencer: only up to 8 phases are served");
        end
    endgenerate

    logic en_meta_ff;
    logic en_sync_ff;
    logic [15:0] rise_time_ff;
    logic [15:0] turn_off_delay_ff;
    logic [15:0] fall_time_ff;
    logic [7:0] stat_sticky_ff;
    logic [15:0] rdata_ff;
    logic ack_ff;
    logic nack_ff;
    orsq_state_type state_ff;
    orsq_state_type nxt_state;
    logic tmr_start;
    logic tmr_abort;
    logic tmr_done;
    orsq_cyc_type tmr_cycles;
    logic multi_phase;
    logic fall_too_short;
    logic powered;
    logic clear_cmd;
    logic [7:0] stat_byte;
    logic [7:0] flt_set;

    // enable arrives from a pin
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_meta_ff <= 1'b0;
            en_sync_ff <= 1'b0;
        end else begin
            en_meta_ff <= i_enable;
            en_sync_ff <= en_meta_ff;
        end
    end

    // three or more phases hand the ramps to the multi-phase logic
    assign multi_phase = (i_phases > 4'h2);
    assign fall_too_short = (orsq_l11_cycles(fall_time_ff) < orsq_cyc_type'(`ORSQ_MIN_FALL_CYC));

    // sequencing states
    always_comb begin
        nxt_state = state_ff;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        tmr_cycles = '0;
        case (state_ff)
            ORSQ_OFF: begin
                if (en_sync_ff) begin
                    nxt_state = ORSQ_TON_WAIT;
                    tmr_start = 1'b1;
                    tmr_cycles = orsq_l11_cycles(i_ton_delay);
                end
            end
            ORSQ_TON_WAIT: begin
                if (!en_sync_ff) begin
                    nxt_state = ORSQ_OFF;
                    tmr_abort = 1'b1;
                end else if (tmr_done) begin
                    nxt_state = ORSQ_RISE;
                    tmr_start = 1'b1;
                    if (multi_phase) begin
                        tmr_cycles = orsq_l11_cycles(i_mp_ramp_gain);
                    end else begin
                        tmr_cycles = orsq_l11_cycles(rise_time_ff);
                    end
                end
            end
            ORSQ_RISE: begin
                // disable mid-rise still honours the turn-off delay
                if (!en_sync_ff) begin
                    nxt_state = ORSQ_TOFF_WAIT;
                    tmr_start = 1'b1;
                    tmr_cycles = orsq_l11_cycles(turn_off_delay_ff);
                end else if (tmr_done) begin
                    nxt_state = ORSQ_ON;
                end
            end
            ORSQ_ON: begin
                if (!en_sync_ff) begin
                    nxt_state = ORSQ_TOFF_WAIT;
                    tmr_start = 1'b1;
                    tmr_cycles = orsq_l11_cycles(turn_off_delay_ff);
                end
            end
            ORSQ_TOFF_WAIT: begin
                if (en_sync_ff) begin
                    // output never left regulation, so no new rise
                    nxt_state = ORSQ_ON;
                    tmr_abort = 1'b1;
                end else if (tmr_done) begin
                    if (multi_phase || fall_too_short) begin
                        nxt_state = ORSQ_OFF;
                    end else begin
                        nxt_state = ORSQ_FALL;
                        tmr_start = 1'b1;
                        tmr_cycles = orsq_l11_cycles(fall_time_ff);
                    end
                end
            end
            ORSQ_FALL: begin
                if (en_sync_ff) begin
                    nxt_state = ORSQ_TON_WAIT;
                    tmr_start = 1'b1;
                    tmr_cycles = orsq_l11_cycles(i_ton_delay);
                end else if (tmr_done) begin
                    nxt_state = ORSQ_OFF;
                end
            end
            default: begin
                nxt_state = ORSQ_OFF;
                tmr_abort = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ORSQ_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    orsq_interval_timer #(
        .CNT_W(`ORSQ_CYC_W)
    ) i_orsq_interval_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(tmr_start),
        .i_abort(tmr_abort),
        .i_cycles(tmr_cycles),
        .o_busy(),
        .o_done(tmr_done)
    );

    assign powered = (state_ff == ORSQ_RISE) || (state_ff == ORSQ_ON)
        || (state_ff == ORSQ_TOFF_WAIT) || (state_ff == ORSQ_FALL);

    // stage drive outputs from flip-flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ramp_up <= 1'b0;
            o_ramp_down <= 1'b0;
            o_stage_on <= 1'b0;
            o_pwm_tristate <= 1'b1;
        end else begin
            o_ramp_up <= (nxt_state == ORSQ_RISE);
            o_ramp_down <= (nxt_state == ORSQ_FALL);
            o_stage_on <= (nxt_state != ORSQ_OFF) && (nxt_state != ORSQ_TON_WAIT);
            o_pwm_tristate <= (nxt_state == ORSQ_OFF) || (nxt_state == ORSQ_TON_WAIT);
        end
    end

    assign o_state = state_ff;

    assign clear_cmd = i_cmd_valid && i_cmd_write && (i_cmd_code == CLEAR_CODE);

    // timing words written by the host; no range check, out-of-range is the host's risk
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rise_time_ff <= `ORSQ_TIME_RST;
            turn_off_delay_ff <= `ORSQ_TIME_RST;
            fall_time_ff <= `ORSQ_TIME_RST;
        end else if (i_cmd_valid && i_cmd_write) begin
            case (i_cmd_code)
                `ORSQ_CMD_RISE_TIME: rise_time_ff <= i_cmd_wdata;
                `ORSQ_CMD_TURN_OFF_DELAY: turn_off_delay_ff <= i_cmd_wdata;
                `ORSQ_CMD_FALL_TIME: fall_time_ff <= i_cmd_wdata;
                default: begin
                end
            endcase
        end
    end

    // fault events; bit 6 is live, not sticky
    always_comb begin
        flt_set = 8'h00;
        flt_set[`ORSQ_ST_BUSY] = i_flt_busy;
        flt_set[`ORSQ_ST_OV] = i_flt_ov;
        flt_set[`ORSQ_ST_OC] = i_flt_oc;
        flt_set[`ORSQ_ST_UVIN] = i_flt_uvin;
        flt_set[`ORSQ_ST_TEMP] = i_flt_temp;
        flt_set[`ORSQ_ST_CML] = i_flt_cml;
        flt_set[`ORSQ_ST_OTHER] = i_flt_other;
    end

    // a fault in the clear cycle survives the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stat_sticky_ff <= `ORSQ_STAT_RST;
        end else if (clear_cmd) begin
            stat_sticky_ff <= flt_set;
        end else begin
            stat_sticky_ff <= stat_sticky_ff | flt_set;
        end
    end

    always_comb begin
        stat_byte = stat_sticky_ff;
        stat_byte[`ORSQ_ST_OFF] = !powered;
    end

    // one register answers both the byte and the low half of the word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else begin
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
            if (i_cmd_valid) begin
                ack_ff <= 1'b1;
                if (i_cmd_write) begin
                    rdata_ff <= 16'h0000;
                    case (i_cmd_code)
                        `ORSQ_CMD_RISE_TIME, `ORSQ_CMD_TURN_OFF_DELAY, `ORSQ_CMD_FALL_TIME: begin
                        end
                        default: begin
                            if (i_cmd_code != CLEAR_CODE) begin
                                ack_ff <= 1'b0;
                                nack_ff <= 1'b1;
                            end
                        end
                    endcase
                end else begin
                    case (i_cmd_code)
                        `ORSQ_CMD_RISE_TIME: rdata_ff <= rise_time_ff;
                        `ORSQ_CMD_TURN_OFF_DELAY: rdata_ff <= turn_off_delay_ff;
                        `ORSQ_CMD_FALL_TIME: rdata_ff <= fall_time_ff;
                        `ORSQ_CMD_STAT_BYTE: rdata_ff <= {8'h00, stat_byte};
                        `ORSQ_CMD_STAT_WORD: rdata_ff <= {i_stat_hi, stat_byte};
                        default: begin
                            rdata_ff <= 16'h0000;
                            ack_ff <= 1'b0;
                            nack_ff <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    assign o_cmd_ack = ack_ff;
    assign o_cmd_nack = nack_ff;
    assign o_cmd_rdata = rdata_ff;

endmodule : orsq_sequencer

// >>> orsq_map.svh
// offsets, field positions, reset values and timing counts of the output ramp sequencer
`ifndef ORSQ_MAP_SVH
`define ORSQ_MAP_SVH

// command codes on the power-management serial bus
`define ORSQ_CMD_RISE_TIME 8'h61
`define ORSQ_CMD_TURN_OFF_DELAY 8'h64
`define ORSQ_CMD_FALL_TIME 8'h65
`define ORSQ_CMD_STAT_BYTE 8'h78
`define ORSQ_CMD_STAT_WORD 8'h79

// reset values
`define ORSQ_TIME_RST 16'hCA80
`define ORSQ_STAT_RST 8'h00

// linear-11 field layout
`define ORSQ_L11_EXP_HI 15
`define ORSQ_L11_EXP_LO 11
`define ORSQ_L11_MAN_HI 10
`define ORSQ_L11_MAN_LO 0

// status summary bit positions
`define ORSQ_ST_BUSY 7
`define ORSQ_ST_OFF 6
`define ORSQ_ST_OV 5
`define ORSQ_ST_OC 4
`define ORSQ_ST_UVIN 3
`define ORSQ_ST_TEMP 2
`define ORSQ_ST_CML 1
`define ORSQ_ST_OTHER 0

// timing
`define ORSQ_CLK_HZ 50000000
`define ORSQ_CYC_PER_MS (`ORSQ_CLK_HZ / 1000)
`define ORSQ_MIN_FALL_US 500
`define ORSQ_MIN_FALL_CYC ((`ORSQ_CLK_HZ / 1000000) * `ORSQ_MIN_FALL_US)
`define ORSQ_CYC_W 48

`endif

// >>> orsq_pkg.sv
// types and the linear-11 to clock-cycle conversion of the output ramp sequencer
`include "orsq_map.svh"

package orsq_pkg;

    typedef logic [`ORSQ_CYC_W-1:0] orsq_cyc_type;

    typedef enum logic [5:0] {
        ORSQ_OFF = 6'b000001,
        ORSQ_TON_WAIT = 6'b000010,
        ORSQ_RISE = 6'b000100,
        ORSQ_ON = 6'b001000,
        ORSQ_TOFF_WAIT = 6'b010000,
        ORSQ_FALL = 6'b100000
    } orsq_state_type;

    // time in ms is mantissa * 2^exponent; negative or zero mantissa means no delay
    function automatic orsq_cyc_type orsq_l11_cycles(input logic [15:0] word);
        logic signed [4:0] expo;
        logic signed [10:0] mant;
        orsq_cyc_type base;
        logic [4:0] sh;
        expo = word[`ORSQ_L11_EXP_HI:`ORSQ_L11_EXP_LO];
        mant = word[`ORSQ_L11_MAN_HI:`ORSQ_L11_MAN_LO];
        base = '0;
        sh = 5'(-expo);
        if (mant > 11'sh000) begin
            base = orsq_cyc_type'($unsigned(mant)) * orsq_cyc_type'(`ORSQ_CYC_PER_MS);
        end
        if (expo < 5'sh00) begin
            orsq_l11_cycles = base >> sh;
        end else begin
            orsq_l11_cycles = base << expo[3:0];
        end
    endfunction : orsq_l11_cycles

endpackage : orsq_pkg

// >>> orsq_interval_timer.sv
// one-shot interval timer counting a loaded number of clock cycles
module orsq_interval_timer #(
    parameter int CNT_W = 48
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [CNT_W-1:0] i_cycles,
    output logic o_busy,
    output logic o_done
);

    logic [CNT_W-1:0] remain_ff;
    logic busy_ff;
    logic done_ff;

    generate
        if (CNT_W < 42) begin : g_width_check
            $error("orsq_interval_timer: CNT_W too small for the longest interval");
        end
    endgenerate

    // a zero interval still takes one cycle so the sequencer always sees done
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            remain_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (i_abort) begin
                busy_ff <= 1'b0;
                remain_ff <= '0;
            end else if (i_start) begin
                busy_ff <= 1'b1;
                remain_ff <= i_cycles;
            end else if (busy_ff) begin
                if (remain_ff <= CNT_W'(1)) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    remain_ff <= '0;
                end else begin
                    remain_ff <= remain_ff - CNT_W'(1);
                end
            end
        end
    end

    assign o_busy = busy_ff;
    assign o_done = done_ff;

endmodule : orsq_interval_timer

// >>> orsq_sequencer_asserts.sv
// concurrent checks on the output ramp sequencer ports
module orsq_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_phases,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic i_flt_busy,
    input wire logic i_flt_ov,
    input wire logic [7:0] i_stat_hi,
    input wire logic o_cmd_nack,
    input wire logic [15:0] o_cmd_rdata,
    input wire logic o_ramp_up,
    input wire logic o_ramp_down,
    input wire logic o_pwm_tristate,
    input wire orsq_pkg::orsq_state_type o_state
);
    import orsq_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(c);
        i_cmd_valid && !i_cmd_write && i_cmd_code == c;
    endsequence
    property p_ro_write;
        i_cmd_valid && i_cmd_write && i_cmd_code == 8'h78 |=> o_cmd_nack;
    endproperty
    property p_byte_hi;
        s_rd(8'h78) |=> o_cmd_rdata[15:8] == 8'h00;
    endproperty
    property p_word_hi;
        s_rd(8'h79) |=> o_cmd_rdata[15:8] == $past(i_stat_hi);
    endproperty
    property p_off_bit;
        s_rd(8'h78) ##0 o_state == ORSQ_OFF |=> o_cmd_rdata[6];
    endproperty
    property p_ov;
        i_flt_ov ##1 s_rd(8'h78) |=> o_cmd_rdata[5];
    endproperty
    property p_busy;
        i_flt_busy ##1 s_rd(8'h78) |=> o_cmd_rdata[7];
    endproperty
    property p_rise;
        o_ramp_up |-> o_state == ORSQ_RISE && !o_pwm_tristate;
    endproperty
    property p_ton_order;
        o_state == ORSQ_RISE |-> $past(o_state) inside {ORSQ_TON_WAIT, ORSQ_RISE};
    endproperty
    property p_fall;
        o_ramp_down |-> o_state == ORSQ_FALL && i_phases <= 4'h2 && !o_pwm_tristate;
    endproperty
    property p_fall_entry;
        o_state == ORSQ_FALL |-> $past(o_state) inside {ORSQ_TOFF_WAIT, ORSQ_FALL};
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status write not refused");
    a_byte_hi: assert property (p_byte_hi) else $error("byte read upper not zero");
    a_word_hi: assert property (p_word_hi) else $error("word upper byte wrong");
    a_off_bit: assert property (p_off_bit) else $error("off bit clear while off");
    a_ov: assert property (p_ov) else $error("overvoltage bit missing");
    a_busy: assert property (p_busy) else $error("busy bit missing");
    a_rise: assert property (p_rise) else $error("rise outside rise state");
    a_ton_order: assert property (p_ton_order) else $error("rise without delay");
    a_fall: assert property (p_fall) else $error("fall ramp not allowed");
    a_fall_entry: assert property (p_fall_entry) else $error("fall without delay");
endmodule : orsq_chk

bind orsq_sequencer orsq_chk i_orsq_chk (.i_clk, .i_rst, .i_phases, .i_cmd_valid, .i_cmd_write,
    .i_cmd_code, .i_flt_busy, .i_flt_ov, .i_stat_hi, .o_cmd_nack, .o_cmd_rdata, .o_ramp_up,
    .o_ramp_down, .o_pwm_tristate, .o_state);

// >>> orsq_host_model.sv
// host controller model issuing decoded bus commands
module orsq_host_model (
    input wire logic i_clk,
    input wire logic i_cmd_ack,
    input wire logic i_cmd_nack,
    input wire logic [15:0] i_cmd_rdata,
    output logic o_cmd_valid,
    output logic o_cmd_write,
    output logic [7:0] o_cmd_code,
    output logic [15:0] o_cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                        output logic ack, output logic nack, output logic [15:0] rd);
        @(negedge i_clk);
        o_cmd_valid = 1'b1;
        o_cmd_write = wr;
        o_cmd_code = code;
        o_cmd_wdata = wd;
        @(negedge i_clk);
        // the answer stands only in the cycle after the taking edge
        ack = i_cmd_ack;
        nack = i_cmd_nack;
        rd = i_cmd_rdata;
        o_cmd_valid = 1'b0;
        // released fields flip so nothing leans on a stale value
        o_cmd_code = ~code;
        o_cmd_wdata = ~wd;
    endtask : xfer
endmodule : orsq_host_model

// >>> orsq_sequencer_tb_top.sv
// self-checking bench for the output ramp sequencer
module orsq_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import orsq_pkg::*;
    logic clk, rst, enable, valid, write, ack, nack, ramp_up, ramp_down, stage_on, tristate;
    logic seen_down;
    logic [3:0] phases;
    logic [7:0] code, flt, stat_hi;
    logic [15:0] ton_delay, mp_gain, wdata, rdata;
    orsq_state_type state;
    int err_count = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (ramp_down) seen_down <= 1'b1;
    orsq_host_model i_orsq_host_model (.i_clk(clk), .i_cmd_ack(ack), .i_cmd_nack(nack),
        .i_cmd_rdata(rdata), .o_cmd_valid(valid), .o_cmd_write(write), .o_cmd_code(code),
        .o_cmd_wdata(wdata));
    orsq_sequencer i_orsq_sequencer (.i_clk(clk), .i_rst(rst), .i_enable(enable),
        .i_phases(phases), .i_ton_delay(ton_delay), .i_mp_ramp_gain(mp_gain),
        .i_cmd_valid(valid), .i_cmd_write(write), .i_cmd_code(code), .i_cmd_wdata(wdata),
        .i_flt_busy(flt[7]), .i_flt_ov(flt[5]), .i_flt_oc(flt[4]), .i_flt_uvin(flt[3]),
        .i_flt_temp(flt[2]), .i_flt_cml(flt[1]), .i_flt_other(flt[0]), .i_stat_hi(stat_hi),
        .o_cmd_ack(ack), .o_cmd_nack(nack), .o_cmd_rdata(rdata), .o_ramp_up(ramp_up),
        .o_ramp_down(ramp_down), .o_stage_on(stage_on), .o_pwm_tristate(tristate),
        .o_state(state));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic rw(input logic wr, input logic [7:0] c, input logic [15:0] wd,
                      input logic [1:0] exp_an, input logic [15:0] exp_rd);
        logic a, n;
        logic [15:0] rd;
        i_orsq_host_model.xfer(wr, c, wd, a, n, rd);
        chk("ack nack", {14'h0000, a, n}, {14'h0000, exp_an});
        if (exp_an == 2'b10) chk("read data", rd, exp_rd);
    endtask : rw
    function automatic logic pick(input int sel);
        case (sel)
            0: return ramp_up;
            1: return ramp_down;
            2: return state == ORSQ_TON_WAIT;
            default: return state != ORSQ_OFF;
        endcase
    endfunction : pick
    // bounded wait for the condition, then cycles it stays true
    task automatic span(input int sel, output int n);
        int w;
        n = 0;
        w = 0;
        while (!pick(sel) && w < 2000) begin
            @(negedge clk);
            w++;
        end
        while (pick(sel) && n < 30000) begin
            @(negedge clk);
            n++;
        end
        // a limit that runs out is a hang, never a pass
        if (w >= 2000 || n >= 30000) begin
            err_count++;
            $display("[FAIL] span %0d expected within limits seen wait %0d count %0d", sel, w, n);
        end
    endtask : span
    task automatic t_reset();
        rw(0, 8'h61, 16'h0000, 2'b10, 16'hCA80);
        rw(0, 8'h64, 16'h0000, 2'b10, 16'hCA80);
        rw(0, 8'h65, 16'h0000, 2'b10, 16'hCA80);
        rw(0, 8'h78, 16'h0000, 2'b10, 16'h0040);
        rw(0, 8'h79, 16'h0000, 2'b10, {stat_hi, 8'h40});
        rw(1, 8'h78, 16'h00FF, 2'b01, 16'h0000);
        rw(0, 8'h70, 16'h0000, 2'b01, 16'h0000);
    endtask : t_reset
    task automatic t_faults();
        logic [7:0] exp;
        exp = 8'h40;
        for (int b = 7; b >= 0; b--) begin
            if (b != 6) begin
                flt[b] = 1'b1;
                exp[b] = 1'b1;
                rw(0, 8'h78, 16'h0000, 2'b10, {8'h00, exp});
                flt = 8'h00;
            end
        end
        rw(0, 8'h79, 16'h0000, 2'b10, {stat_hi, exp});
        rw(1, 8'h03, 16'h0000, 2'b10, 16'h0000);
        rw(0, 8'h78, 16'h0000, 2'b10, 16'h0040);
    endtask : t_faults
    // rise word B001h is 48 cycles, ramp word F801h 25000, delay B001h 48
    task automatic t_seq(input logic [3:0] ph, input logic [15:0] fall,
                         input logic [15:0] rise_n, input logic ramp);
        int n;
        phases = ph;
        rw(1, 8'h61, 16'hB001, 2'b10, 16'h0000);
        rw(1, 8'h65, fall, 2'b10, 16'h0000);
        rw(1, 8'h64, 16'hB001, 2'b10, 16'h0000);
        rw(0, 8'h65, 16'h0000, 2'b10, fall);
        enable = 1'b1;
        span(2, n);
        chk("ton wait cycles", 16'(n), 16'h0031);
        span(0, n);
        chk("rise cycles", 16'(n), rise_n);
        chk("stage on", {15'h0000, stage_on}, 16'h0001);
        rw(0, 8'h78, 16'h0000, 2'b10, 16'h0000);
        seen_down = 1'b0;
        enable = 1'b0;
        if (ramp) begin
            span(1, n);
            chk("fall span ok", {15'h0000, n >= 25000 && n <= 25001}, 16'h0001);
        end else begin
            span(3, n);
        end
        chk("fall ramp seen", {15'h0000, seen_down}, {15'h0000, ramp});
        chk("tristate", {15'h0000, tristate}, 16'h0001);
        rw(0, 8'h78, 16'h0000, 2'b10, 16'h0040);
    endtask : t_seq
    // early disable drops back off; re-enable in the turn-off delay keeps regulating
    task automatic t_abort();
        phases = 4'h1;
        enable = 1'b1;
        repeat (10) @(negedge clk);
        chk("ton wait held", {10'h000, state}, 16'h0002);
        enable = 1'b0;
        repeat (4) @(negedge clk);
        chk("off after early disable", {10'h000, state}, 16'h0001);
        enable = 1'b1;
        repeat (120) @(negedge clk);
        chk("on after rise", {10'h000, state}, 16'h0008);
        enable = 1'b0;
        repeat (10) @(negedge clk);
        chk("toff wait", {10'h000, state}, 16'h0010);
        enable = 1'b1;
        repeat (4) @(negedge clk);
        chk("back on", {10'h000, state}, 16'h0008);
        chk("no new rise", {15'h0000, ramp_up}, 16'h0000);
    endtask : t_abort
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        enable = 1'b0;
        phases = 4'h1;
        ton_delay = 16'hB001;
        mp_gain = 16'hB002;
        flt = 8'h00;
        stat_hi = 8'h5A;
        seen_down = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_faults();
        t_seq(4'h1, 16'hF801, 16'h0031, 1'b1);
        t_seq(4'h2, 16'hB001, 16'h0031, 1'b0);
        t_seq(4'h4, 16'hF801, 16'h0062, 1'b0);
        t_abort();
        give_verdict();
    end
    // about twice the expected run
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
endmodule : orsq_sequencer_tb_top
